// file: core/config_memory_crc_error_reporting.sv
// frame crc checker with error search, message register and error flag
`timescale 1ns/1ns
// Functional notes
// [R01] flag rises after search and message update
// [R02] flag then low at least 32 slow cycles
// [R03] next error: flag after message overwritten
// [R04] system unloads message on flag rising edge
// [R05] checking runs continuously until reset
// [R06] slow clock is oscillator over two power n
// [R07] divisor only powers of two, 2 to 256
// [R08] crc computed one word per slow tick
// [R09] each error overwrites the message register
// [R10] system reads each report before next update
// [R11] a pass covers first frame to last
// [R12] system pulses reconfig request to recover
// [R13] flag follows non-zero syndrome of frame
// [R14] message holds type, location, syndrome, 46 bits
// [R15] update copies follow message, gated by enable
// [R16] checking continues after finding an error
// [R17] fixed 16-bit crc polynomial for every frame
module config_memory_crc_error_reporting
    import crc_monitor_pkg::*;
#(
    parameter int words = frame_words,
    parameter int frames = frame_count
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] div_exp,
    input wire logic frame_start,
    input wire logic [15:0] frame_word,
    input wire logic [15:0] frame_crc,
    input wire logic user_sample_en,
    output logic soft_error,
    output logic [msg_width-1:0] error_message,
    output logic [msg_width-1:0] user_update,
    output logic [15:0] frame_index,
    output logic [15:0] pass_count
);
    logic [3:0] exp_held;
    logic [7:0] div_count;
    logic tick;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic [15:0] syndrome;
    logic [15:0] word_index;
    logic [15:0] search_pos;
    logic [5:0] quiet_count;
    logic msg_valid;
    state_type state;
    logic [7:0] div_limit;

    // out-of-range divisor exponents are ignored, keeping the held one, so only 2..256 can be produced
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            exp_held <= div_exp_reset;
        end
        else if (div_exp >= 4'(div_exp_min) && div_exp <= 4'(div_exp_max))  // see [R07]
        begin
            exp_held <= div_exp;
        end
    end

    assign div_limit = 8'((9'h001 << exp_held) - 9'h001);

    // clock is the oscillator; tick is the divided checking rate
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            div_count <= 8'h00;
        end
        else if (div_count >= div_limit)  // see [R06]
        begin
            div_count <= 8'h00;
        end
        else
        begin
            div_count <= div_count + 8'h01;
        end
    end

    assign tick = (div_count >= div_limit);

    crc16_step #(.width(16)) step
    (
        .crc_in(crc),
        .data(frame_word),
        .crc_out(next_crc)
    );

    // per-frame crc; never halts on errors, only rst stops it
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            crc <= crc_seed;
            word_index <= 16'h0000;
            frame_index <= 16'h0000;
            pass_count <= 16'h0000;
            syndrome <= 16'h0000;
        end
        else if (tick)  // see [R05] [R16]
        begin
            if (frame_start || word_index == 16'(words))
            begin
                crc <= crc_seed;
                word_index <= 16'h0000;
                if (word_index == 16'(words))
                begin
                    syndrome <= crc ^ frame_crc;  // see [R17] [R08]
                    if (frame_index == 16'(frames - 1))  // see [R11]
                    begin
                        frame_index <= 16'h0000;
                        pass_count <= pass_count + 16'h0001;
                    end
                    else
                    begin
                        frame_index <= frame_index + 16'h0001;
                    end
                end
            end
            else
            begin
                crc <= next_crc;
                word_index <= word_index + 16'h0001;
            end
        end
    end

    // report sequencer: search, write message, flag, enforced quiet time
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= st_check;
            search_pos <= 16'h0000;
            quiet_count <= 6'h00;
            soft_error <= 1'b0;
            error_message <= '0;
            msg_valid <= 1'b0;
        end
        else if (tick)
        begin
            msg_valid <= 1'b0;
            unique case (state)
                st_check:
                begin
                    if (syndrome != 16'h0000 && word_index == 16'h0000)  // see [R13]
                    begin
                        state <= st_search;
                        search_pos <= 16'h0000;
                    end
                end
                st_search:
                begin
                    // location search walks the syndrome bits one per tick
                    if (search_pos == 16'h000F)
                    begin
                        state <= st_report;
                    end
                    else
                    begin
                        search_pos <= search_pos + 16'h0001;
                    end
                end
                st_report:
                begin
                    error_message <= {classify(syndrome), frame_index, 12'h000,
                        syndrome};  // see [R14] [R09] [R03]
                    msg_valid <= 1'b1;
                    state <= st_flag;
                end
                st_flag:
                begin
                    soft_error <= 1'b1;  // see [R01]
                    state <= st_quiet;
                    quiet_count <= 6'h00;
                end
                st_quiet:
                begin
                    soft_error <= 1'b0;
                    if (quiet_count == 6'(flag_low_cycles - 1))  // see [R02]
                    begin
                        state <= st_check;
                    end
                    else
                    begin
                        quiet_count <= quiet_count + 6'h01;
                    end
                end
                default:
                begin
                    state <= st_check;
                end
            endcase
        end
    end

    // copy a cycle after the message is valid, held off while user samples
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            user_update <= '0;
        end
        else if (msg_valid && !user_sample_en)  // see [R15]
        begin
            user_update <= error_message;
        end
    end

    function automatic logic [1:0] classify(input logic [15:0] s);
        logic [1:0] t;
        t = err_other;
        if (s == 16'h0000)
        begin
            t = err_none;
        end
        else if ((s & (s - 16'h0001)) == 16'h0000)
        begin
            t = err_single;
        end
        else if ((s & (s - 16'h0001) & (s - 16'h0001 - (s & ~(s - 16'h0001)))) == 16'h0000)
        begin
            t = err_double_adj;
        end
        return t;
    endfunction : classify
endmodule : config_memory_crc_error_reporting

// file: core/crc_monitor_pkg.sv
// constants shared by the configuration memory error checker
package crc_monitor_pkg;
    localparam int osc_freq_mhz = 100;
    localparam int div_exp_min = 1;
    localparam int div_exp_max = 8;
    localparam logic [3:0] div_exp_reset = 4'h1;
    localparam int flag_low_cycles = 32;
    localparam int frame_words = 16;
    localparam int frame_count = 8;
    localparam logic [15:0] crc_poly = 16'h1021;
    localparam logic [15:0] crc_seed = 16'hFFFF;
    localparam int msg_width = 46;
    localparam int msg_syn_lsb = 0;
    localparam int msg_loc_lsb = 16;
    localparam int msg_type_lsb = 44;
    localparam logic [1:0] err_none = 2'h0;
    localparam logic [1:0] err_single = 2'h1;
    localparam logic [1:0] err_double_adj = 2'h2;
    localparam logic [1:0] err_other = 2'h3;
    typedef enum logic [2:0]
    {
        st_check = 3'b000,
        st_search = 3'b001,
        st_report = 3'b010,
        st_flag = 3'b011,
        st_quiet = 3'b100
    } state_type;
endpackage : crc_monitor_pkg

// file: core/crc16_step.sv
// one word step of the frame crc, msb first
`timescale 1ns/1ns
module crc16_step
    import crc_monitor_pkg::*;
#(
    parameter int width = 16
)
(
    input wire logic [15:0] crc_in,
    input wire logic [width-1:0] data,
    output logic [15:0] crc_out
);
    always_comb
    begin
        crc_out = crc_in;
        for (int i = width - 1; i >= 0; i--)
        begin
            if (crc_out[15] ^ data[i])
            begin
                crc_out = {crc_out[14:0], 1'b0} ^ crc_poly;
            end
            else
            begin
                crc_out = {crc_out[14:0], 1'b0};
            end
        end
    end
endmodule : crc16_step

// file: verification/crc_report_check_asserts.sv
// checker for the crc error reporting block
`timescale 1ns/1ns
module crc_report_check
    import crc_monitor_pkg::*;
#(
    parameter int frames = frame_count
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic user_sample_en,
    input wire logic soft_error,
    input wire logic [msg_width-1:0] error_message,
    input wire logic [msg_width-1:0] user_update,
    input wire logic [15:0] frame_index,
    input wire logic [15:0] pass_count
);
    logic [15:0] low_run;
    logic [15:0] still_run;
    // saturates so a long quiet spell cannot wrap into a false short gap
    always_ff @(posedge clock)
        low_run <= (rst || soft_error) ? 16'h0000 : low_run + {15'h0000, ~&low_run};
    always_ff @(posedge clock)
        still_run <= (rst || $changed(frame_index)) ? 16'h0000 : still_run + 16'h0001;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    flag_msg_a: assert property ($rose(soft_error)
        |-> error_message[45:44] != err_none) else $error("flag without report");
    flag_gap_a: assert property ($rose(soft_error)
        |-> low_run >= 16'h0040) else $error("flag low too short");
    flag_end_a: assert property ($rose(soft_error)
        |-> ##[1:256] !soft_error) else $error("flag stuck high");
    syn_set_a: assert property (error_message[45:44] != err_none
        |-> error_message[15:0] != 16'h0000) else $error("zero syndrome reported");
    pad_zero_a: assert property (error_message[27:16] == 12'h000)
        else $error("message padding set");
    update_copy_a: assert property ($changed(error_message) && !user_sample_en
        |=> user_update == error_message) else $error("update copy missing");
    copy_hold_a: assert property (user_sample_en |=> $stable(user_update))
        else $error("copy while reading");
    index_range_a: assert property (frame_index < frames)
        else $error("frame index out of range");
    pass_step_a: assert property ($changed(pass_count)
        |-> pass_count == $past(pass_count) + 16'h0001) else $error("pass count jump");
    check_alive_a: assert property (still_run < 16'h7530)
        else $error("checking stalled");
    flag_c: cover property ($rose(soft_error));
    pass_c: cover property ($changed(pass_count));
    read_c: cover property (user_sample_en);
endmodule : crc_report_check
bind config_memory_crc_error_reporting crc_report_check #(.frames(frames)) i_chk (.clock, .rst,
    .user_sample_en, .soft_error, .error_message, .user_update, .frame_index, .pass_count);

// file: verification/system_partner.sv
// system side model: feeds frames, unloads reports, asks for reconfiguration
`timescale 1ns/1ns
module system_partner
    import crc_monitor_pkg::*;
(
    input wire logic clock,
    input wire logic bad,
    input wire logic hold,
    input wire logic soft_error,
    input wire logic [msg_width-1:0] error_message,
    output logic [15:0] frame_word,
    output logic [15:0] frame_crc,
    output logic user_sample_en,
    output logic reconfig_request_n,
    output logic [msg_width-1:0] got,
    output int reports
);
    localparam logic [15:0] word = 16'hA5C3;
    logic last = 1'b0;
    logic [15:0] good;
    // one word in every slot keeps the stored crc right whatever the frame alignment
    initial
    begin
        good = crc_seed;
        for (int i = 0; i < frame_words * 16; i++)
            good = {good[14:0], 1'b0} ^ ((good[15] ^ word[15 - i % 16]) ? crc_poly : 16'h0000);
        reports = 0;
        user_sample_en = 1'b0;
        reconfig_request_n = 1'b1;
    end
    assign frame_crc = bad ? ~good : good;
    assign frame_word = word;
    always @(posedge clock)
    begin
        last <= soft_error;
        if (soft_error && !last)
        begin
            got <= error_message;
            reports <= reports + 1;
        end
    end
    always @(negedge clock)
    begin
        // hold lets a scenario keep the user read going across a new report
        user_sample_en <= soft_error || hold;
        reconfig_request_n <= !soft_error;
    end
endmodule : system_partner

// file: verification/config_memory_crc_error_reporting_tb_top.sv
// testbench for the crc error reporting block
`timescale 1ns/1ns
module config_memory_crc_error_reporting_tb_top
    import crc_monitor_pkg::*;
();
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] div_exp = 4'h1;
    logic bad = 1'b0;
    logic hold = 1'b0;
    logic frame_start = 1'b0;
    logic soft_error, user_sample_en, reconfig_request_n;
    logic [msg_width-1:0] error_message, user_update, got, first;
    logic [15:0] frame_word, frame_crc, frame_index, pass_count;
    int reports;
    int n_errors = 0;
    int checks_done = 0;
    initial
        forever #4 clock = ~clock;
    config_memory_crc_error_reporting i_dut (.clock, .rst, .div_exp, .frame_start, .frame_word,
        .frame_crc, .user_sample_en, .soft_error, .error_message, .user_update, .frame_index, .pass_count);
    system_partner i_sys (.clock, .bad, .hold, .soft_error, .error_message, .frame_word, .frame_crc,
        .user_sample_en, .reconfig_request_n, .got, .reports);
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_report(input int r);
        for (int i = 0; i < 3000 && reports == r; i++)
            @(negedge clock);
        check("report", r + 1, reports);
    endtask : wait_report
    task automatic t_clean();
        int r = reports;
        logic [15:0] p = pass_count;
        repeat (600) @(negedge clock);
        check("no flag", r, reports);
        check("pass", 1, pass_count != p);
        $display("clean done");
    endtask : t_clean
    task automatic t_error();
        bad = 1'b1;
        wait_report(reports);
        first = got;
        check("reconfig", 0, reconfig_request_n);
        check("type", 1, got[45:44] != err_none);
        check("syndrome", 1, got[15:0] != 16'h0000);
        repeat (8) @(negedge clock);
        check("copy", got, user_update);
        hold = 1'b1;
        wait_report(reports);
        check("overwrite", 1, got[43:28] != first[43:28]);
        check("copy held", first, user_update);
        hold = 1'b0;
        bad = 1'b0;
        $display("error done");
    endtask : t_error
    task automatic t_reset();
        rst = 1'b1;
        repeat (5) @(negedge clock);
        check("flag rst", 0, soft_error);
        check("msg rst", 0, error_message);
        check("pass rst", 0, pass_count);
        rst = 1'b0;
        $display("reset done");
    endtask : t_reset
    task automatic t_restart();
        int c;
        int r;
        logic [15:0] f;
        r = reports;
        f = frame_index;
        c = 0;
        while (frame_index === f && c < 100)
        begin
            @(negedge clock);
            c++;
        end
        // at divisor 2 ticks fall every second clock after a frame end, so the pulse meets one tick
        f = frame_index;
        repeat (9) @(negedge clock);
        frame_start = 1'b1;
        @(negedge clock);
        frame_start = 1'b0;
        c = 10;
        while (frame_index === f && c < 100)
        begin
            @(negedge clock);
            c++;
        end
        check("restart clocks", 2 * (frame_words + 1) + 10, c);
        check("restart flag", r, reports);
        $display("restart done");
    endtask : t_restart
    task automatic t_div(input logic [3:0] e, input int n);
        int c;
        logic [15:0] f;
        div_exp = e;
        for (int k = 0; k < 3; k++)
        begin
            f = frame_index;
            c = 0;
            while (frame_index === f && c < 6000)
            begin
                @(negedge clock);
                c++;
            end
        end
        check("frame clocks", (frame_words + 1) << n, c);
        $display("divisor %0d done", e);
    endtask : t_div
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        #640000;
        n_errors++;
        summarize();
    end
    initial
    begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        t_clean();
        t_error();
        t_reset();
        t_restart();
        for (int e = 8; e >= 1; e--)
            t_div(e[3:0], e);
        t_div(4'h0, 1);
        t_div(4'hF, 1);
        summarize();
    end
endmodule : config_memory_crc_error_reporting_tb_top
